// ===== src/cstr_core.sv
/*
 * execution core for set ones, subtracts, nibble swap, power down and
 * table fetch, with file memory, watchdog and a register port.
 * assumes program memory data arrive the cycle after pm_rd_o.
 */
`default_nettype none

module cstr_core
    import cstr_pkg::*;
(
    input  wire logic                 clk_sys_i,       // core clock
    input  wire logic                 sys_rst_i,       // sync reset
    input  wire cstr_pkg::cstr_bus_req_t bus_i,        // register port
    output logic [7:0]                bus_rdata_o,     // read data
    input  wire logic [15:0]          instr_i,         // instruction
    input  wire logic                 instr_valid_i,   // instr offered
    output logic                      instr_ready_o,   // instr taken
    output logic                      pm_rd_o,         // prog mem read
    output logic [19:0]               pm_addr_o,       // word address
    input  wire logic [15:0]          pm_data_i,       // program word
    input  wire logic                 wake_i,          // wake event
    output logic                      sleep_o,         // osc halted
    output logic                      wdt_timeout_o    // wdog overflow
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        cstr_state_t        st;
        logic [1:0]         ph;
        logic [15:0]        ir;
        cstr_op_t           op;
        logic [7:0]         opnd;
        logic [7:0]         res;
        cstr_flags_t        res_flg;
        logic               flg_we;
        logic [7:0]         working_register;
        logic [3:0]         bnk;
        cstr_flags_t        flg;
        logic [TPTR_W-1:0]  tptr;
        logic [7:0]         tlat;
        logic               to;
        logic               pd;
        logic [7:0]         wdt;
        logic [7:0]         wps;
        logic               wdto;
        logic [7:0]         rdata;
    } cstr_core_st_t;

    cstr_core_st_t r;
    cstr_core_st_t n;

    logic [7:0] dmem [0:(1<<DMEM_AW)-1];

    logic                core_we;
    logic [DMEM_AW-1:0]  core_wa;
    logic                bus_mem_we;
    logic [DMEM_AW-1:0]  fa;
    logic [7:0]          alu_res;
    cstr_flags_t         alu_flg;
    logic                alu_fwe;
    logic [TPTR_W-1:0]   tptr_nxt;
    logic [7:0]          pm_byte;
    logic                wdt_tick;

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------
    function automatic cstr_op_t decode(input logic [15:0] ir);
        cstr_op_t op;
        op = OP_NOP;
        if (ir[15:9] == OPC_SET_ONES)       op = OP_SET_ONES;
        else if (ir[15:10] == OPC_RSUB_BRW) op = OP_RSUB_BRW;
        else if (ir[15:8] == OPC_LIT_SUB)   op = OP_LIT_SUB;
        else if (ir[15:10] == OPC_FILE_SUB) op = OP_FILE_SUB;
        else if (ir[15:10] == OPC_FSUB_BRW) op = OP_FSUB_BRW;
        else if (ir[15:10] == OPC_NIB_SWAP) op = OP_NIB_SWAP;
        else if (ir == OPC_POWERDOWN)       op = OP_POWERDOWN;
        else if (ir[15:2] == OPC_TBL_FETCH) op = OP_TBL_FETCH;
        return op;
    endfunction

    // file address from bank bit, bank select and 8-bit operand
    function automatic logic [DMEM_AW-1:0] file_addr(
        input logic [15:0] ir,
        input logic [3:0]  bnk
    );
        logic [7:0] f;
        f = ir[DATA_W-1:0];
        if (ir[IR_BANK_BIT])
            return {bnk, f};
        else if (f < ACC_SPLIT)
            return {ACC_LO_BANK, f};
        else
            return {ACC_HI_BANK, f};
    endfunction

    function automatic logic is_reg(
        input cstr_bus_req_t b,
        input logic [BUS_AW-1:0] off
    );
        return !b.addr[DMEM_SEL_BIT] && (b.addr == off);
    endfunction

    // ----------------------------------------------------------------
    // datapath pieces
    // ----------------------------------------------------------------
    assign fa = file_addr(r.ir, r.bnk);

    cstr_alu u_alu
    (
        .op_i   (r.op),
        .f_i    (r.opnd),
        .w_i    (r.working_register),
        .lit_i  (r.ir[DATA_W-1:0]),
        .flg_i  (r.flg),
        .res_o  (alu_res),
        .flg_o  (alu_flg),
        .fwe_o  (alu_fwe)
    );

    cstr_table_pointer u_table_pointer
    (
        .ptr_i  (r.tptr),
        .mode_i (r.ir[1:0]),
        .pre_i  (r.st == ST_EXEC),
        .word_i (pm_data_i),
        .ptr_o  (tptr_nxt),
        .byte_o (pm_byte)
    );

    assign wdt_tick = (r.wps == WDT_PS_MAX);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        n         = r;
        n.wdto    = 1'b0;
        core_we   = 1'b0;
        core_wa   = fa;
        // free running watchdog with postscaler
        n.wps = r.wps + 8'h01;
        if (wdt_tick)
        begin
            n.wdt = r.wdt + 8'h01;
            if (r.wdt == ALL_ONES)
                n.wdto = 1'b1;
        end

        case (r.st)
            ST_IDLE:
            begin
                n.ph = PH_Q1;
                if (instr_valid_i)
                begin
                    n.ir = instr_i;
                    n.op = decode(instr_i);
                    n.st = ST_EXEC;
                    n.ph = PH_Q2;
                end
            end
            ST_EXEC:
            begin
                n.ph = r.ph + 2'h1;
                case (r.ph)
                    PH_Q2: n.opnd = dmem[fa];
                    PH_Q3:
                    begin
                        n.res     = alu_res;
                        n.res_flg = alu_flg;
                        n.flg_we  = alu_fwe;
                        if (r.op == OP_TBL_FETCH)
                            n.tptr = tptr_nxt;
                    end
                    PH_Q4:
                    begin
                        n.st = ST_IDLE;
                        if (r.flg_we)
                            n.flg = r.res_flg;
                        case (r.op)
                            OP_SET_ONES:
                                core_we = 1'b1;
                            OP_LIT_SUB:
                                n.working_register = r.res;
                            OP_RSUB_BRW, OP_FILE_SUB,
                            OP_FSUB_BRW, OP_NIB_SWAP:
                            begin
                                if (r.ir[IR_DEST_BIT])
                                    core_we = 1'b1;
                                else
                                    n.working_register = r.res;
                            end
                            OP_POWERDOWN:
                            begin
                                n.st  = ST_SLEEP;
                                n.to  = 1'b1;
                                n.pd  = 1'b0;
                                n.wdt = ZERO_B;
                                n.wps = ZERO_B;
                                n.wdto = 1'b0;
                            end
                            OP_TBL_FETCH:
                                n.st = ST_TBL;
                            default: ;
                        endcase
                    end
                    default: ;
                endcase
            end
            ST_TBL:
            begin
                n.ph = r.ph + 2'h1;
                case (r.ph)
                    PH_Q2: n.opnd = pm_byte;
                    PH_Q4:
                    begin
                        n.tlat = r.opnd;
                        n.tptr = tptr_nxt;
                        n.st   = ST_IDLE;
                    end
                    default: ;
                endcase
            end
            ST_SLEEP:
            begin
                n.ph = PH_Q1;
                if (wdt_tick && r.wdt == ALL_ONES)
                begin
                    n.to   = 1'b0;
                    n.st   = ST_IDLE;
                end
                else if (wake_i)
                    n.st = ST_IDLE;
            end
            default: n.st = ST_IDLE;
        endcase

        // register port, writes land after the core
        n.rdata = ZERO_B;
        if (bus_i.re)
        begin
            if (bus_i.addr[DMEM_SEL_BIT])
                n.rdata = dmem[bus_i.addr[DMEM_AW-1:0]];
            else if (is_reg(bus_i, REG_WORKING)) n.rdata = r.working_register;
            else if (is_reg(bus_i, REG_BANKSEL)) n.rdata = {4'h0, r.bnk};
            else if (is_reg(bus_i, REG_STATUS))  n.rdata = {3'h0, r.flg};
            else if (is_reg(bus_i, REG_TPTR_L))  n.rdata = r.tptr[7:0];
            else if (is_reg(bus_i, REG_TPTR_H))  n.rdata = r.tptr[15:8];
            else if (is_reg(bus_i, REG_TPTR_U))
                n.rdata = {3'h0, r.tptr[TPTR_W-1:16]};
            else if (is_reg(bus_i, REG_TLATCH))  n.rdata = r.tlat;
            else if (is_reg(bus_i, REG_POWER))
                n.rdata = {5'h00, r.st == ST_SLEEP, r.to, r.pd};
            else if (is_reg(bus_i, REG_WDOG))    n.rdata = r.wdt;
        end
        if (bus_i.we)
        begin
            if (is_reg(bus_i, REG_WORKING)) n.working_register = bus_i.wdata;
            if (is_reg(bus_i, REG_BANKSEL)) n.bnk  = bus_i.wdata[3:0];
            if (is_reg(bus_i, REG_STATUS))  n.flg  = bus_i.wdata[4:0];
            if (is_reg(bus_i, REG_TPTR_L))  n.tptr[7:0]  = bus_i.wdata;
            if (is_reg(bus_i, REG_TPTR_H))  n.tptr[15:8] = bus_i.wdata;
            if (is_reg(bus_i, REG_TPTR_U))
                n.tptr[TPTR_W-1:16] = bus_i.wdata[4:0];
            if (is_reg(bus_i, REG_TLATCH))  n.tlat = bus_i.wdata;
        end
    end

    assign bus_mem_we = bus_i.we && bus_i.addr[DMEM_SEL_BIT];

    // ----------------------------------------------------------------
    // registers and file memory
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            r       <= '0;
            r.st    <= ST_IDLE;
            r.op    <= OP_NOP;
            r.flg   <= FLAGS_RST;
            r.to    <= TO_RST;
            r.pd    <= PD_RST;
        end
        else
        begin
            r <= n;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (core_we)
            dmem[core_wa] <= r.res;
        if (bus_mem_we)
            dmem[bus_i.addr[DMEM_AW-1:0]] <= bus_i.wdata;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign instr_ready_o = (r.st == ST_IDLE);
    assign pm_rd_o       = (r.st == ST_TBL) && (r.ph == PH_Q1);
    assign pm_addr_o     = r.tptr[TPTR_W-1:1];
    assign sleep_o       = (r.st == ST_SLEEP);
    assign wdt_timeout_o = r.wdto;
    assign bus_rdata_o   = r.rdata;

endmodule

`default_nettype wire

// ===== src/cstr_pkg.sv
/*
 * shared constants and types of the subtract, swap and table read core:
 * opcode patterns, register map, flag layout, states and phases.
 * assumes one 100 MHz clock and a synchronous, active high reset.
 */
`default_nettype none

package cstr_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int DATA_W  = 8;
    localparam int INSTR_W = 16;
    localparam int BUS_AW  = 13;
    localparam int DMEM_AW = 12;
    localparam int TPTR_W  = 21;
    localparam int PM_AW   = 20;
    localparam int BANK_W  = 4;
    localparam int NIB_W   = 4;

    // ----------------------------------------------------------------
    // opcode patterns
    // ----------------------------------------------------------------
    localparam logic [6:0]  OPC_SET_ONES  = 7'h34;   // 0110 100a
    localparam logic [5:0]  OPC_RSUB_BRW  = 6'h15;   // 0101 01da
    localparam logic [7:0]  OPC_LIT_SUB   = 8'h08;   // 0000 1000
    localparam logic [5:0]  OPC_FILE_SUB  = 6'h17;   // 0101 11da
    localparam logic [5:0]  OPC_FSUB_BRW  = 6'h16;   // 0101 10da
    localparam logic [5:0]  OPC_NIB_SWAP  = 6'h0e;   // 0011 10da
    localparam logic [15:0] OPC_POWERDOWN = 16'h0003;
    localparam logic [13:0] OPC_TBL_FETCH = 14'h0002; // ... 10nn

    // instruction word fields
    localparam int IR_DEST_BIT = 9;
    localparam int IR_BANK_BIT = 8;

    // ----------------------------------------------------------------
    // operations, states, phases
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP       = 4'h0,
        OP_SET_ONES  = 4'h1,
        OP_RSUB_BRW  = 4'h2,
        OP_LIT_SUB   = 4'h3,
        OP_FILE_SUB  = 4'h4,
        OP_FSUB_BRW  = 4'h5,
        OP_NIB_SWAP  = 4'h6,
        OP_POWERDOWN = 4'h7,
        OP_TBL_FETCH = 4'h8
    } cstr_op_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_EXEC  = 4'b0010,
        ST_TBL   = 4'b0100,
        ST_SLEEP = 4'b1000
    } cstr_state_t;

    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;

    // table pointer modes
    localparam logic [1:0] TBL_KEEP    = 2'h0;
    localparam logic [1:0] TBL_POSTINC = 2'h1;
    localparam logic [1:0] TBL_POSTDEC = 2'h2;
    localparam logic [1:0] TBL_PREINC  = 2'h3;
    localparam logic [TPTR_W-1:0] TPTR_STEP = 21'h000001;

    // ----------------------------------------------------------------
    // status flags, n ov z dc c from msb down
    // ----------------------------------------------------------------
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } cstr_flags_t;

    localparam cstr_flags_t FLAGS_RST = 5'h00;
    localparam logic [DATA_W-1:0] ALL_ONES = 8'hff;
    localparam logic [DATA_W-1:0] ZERO_B   = 8'h00;

    // access bank split
    localparam logic [DATA_W-1:0] ACC_SPLIT   = 8'h80;
    localparam logic [BANK_W-1:0] ACC_LO_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hf;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [BUS_AW-1:0] REG_WORKING = 13'h0000;
    localparam logic [BUS_AW-1:0] REG_BANKSEL = 13'h0001;
    localparam logic [BUS_AW-1:0] REG_STATUS  = 13'h0002;
    localparam logic [BUS_AW-1:0] REG_TPTR_L  = 13'h0003;
    localparam logic [BUS_AW-1:0] REG_TPTR_H  = 13'h0004;
    localparam logic [BUS_AW-1:0] REG_TPTR_U  = 13'h0005;
    localparam logic [BUS_AW-1:0] REG_TLATCH  = 13'h0006;
    localparam logic [BUS_AW-1:0] REG_POWER   = 13'h0007;
    localparam logic [BUS_AW-1:0] REG_WDOG    = 13'h0008;
    localparam int DMEM_SEL_BIT = 12;

    // power register bits
    localparam int PWR_PD_BIT    = 0;
    localparam int PWR_TO_BIT    = 1;
    localparam int PWR_SLEEP_BIT = 2;

    localparam logic PD_RST = 1'b1;
    localparam logic TO_RST = 1'b1;

    // watchdog postscaler wrap value
    localparam logic [DATA_W-1:0] WDT_PS_MAX = 8'hff;

    // ----------------------------------------------------------------
    // register port request
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [BUS_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
        logic              re;
    } cstr_bus_req_t;

endpackage

`default_nettype wire

// ===== src/cstr_alu.sv
/*
 * result and flag logic for set, swap and the four subtract forms.
 * assumes the caller samples the outputs in the process phase.
 */
`default_nettype none

module cstr_alu
(
    input  wire cstr_pkg::cstr_op_t    op_i,   // operation
    input  wire logic [7:0]            f_i,    // file operand
    input  wire logic [7:0]            w_i,    // working register
    input  wire logic [7:0]            lit_i,  // literal
    input  wire cstr_pkg::cstr_flags_t flg_i,  // current flags
    output logic [7:0]                 res_o,  // result
    output cstr_pkg::cstr_flags_t      flg_o,  // new flags
    output logic                       fwe_o   // flags change
);
    import cstr_pkg::*;

    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic       sub;
    logic [4:0] lo;
    logic [8:0] sum;

    always_comb
    begin
        a     = ZERO_B;
        b     = ZERO_B;
        cin   = 1'b0;
        sub   = 1'b0;
        res_o = f_i;
        flg_o = flg_i;
        fwe_o = 1'b0;
        case (op_i)
            OP_SET_ONES: res_o = ALL_ONES;
            OP_NIB_SWAP: res_o = {f_i[NIB_W-1:0],
                                  f_i[DATA_W-1:NIB_W]};
            OP_RSUB_BRW:
            begin
                a = w_i; b = f_i; cin = flg_i.c; sub = 1'b1;
            end
            OP_LIT_SUB:
            begin
                a = lit_i; b = w_i; cin = 1'b1; sub = 1'b1;
            end
            OP_FILE_SUB:
            begin
                a = f_i; b = w_i; cin = 1'b1; sub = 1'b1;
            end
            OP_FSUB_BRW:
            begin
                a = f_i; b = w_i; cin = flg_i.c; sub = 1'b1;
            end
            default: ;
        endcase
        // two's complement: a + ~b + carry, carry low means borrow
        lo  = {1'b0, a[NIB_W-1:0]} + {1'b0, ~b[NIB_W-1:0]}
            + {4'h0, cin};
        sum = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        if (sub)
        begin
            res_o    = sum[DATA_W-1:0];
            flg_o.c  = sum[DATA_W];
            flg_o.dc = lo[NIB_W];
            flg_o.ov = (a[DATA_W-1] ^ b[DATA_W-1])
                     & (sum[DATA_W-1] ^ a[DATA_W-1]);
            flg_o.n  = sum[DATA_W-1];
            flg_o.z  = (sum[DATA_W-1:0] == ZERO_B);
            fwe_o    = 1'b1;
        end
    end

endmodule

`default_nettype wire

// ===== src/cstr_table_pointer.sv
/*
 * next value of the byte pointer for a table fetch and the byte pick
 * out of a program word. assumes pre_i is high only in the execute state.
 */
`default_nettype none

module cstr_table_pointer
(
    input  wire logic [20:0] ptr_i,   // current pointer
    input  wire logic [1:0]  mode_i,  // pointer mode
    input  wire logic        pre_i,   // execute state of fetch
    input  wire logic [15:0] word_i,  // program word
    output logic [20:0]      ptr_o,   // next pointer
    output logic [7:0]       byte_o   // picked byte
);
    import cstr_pkg::*;

    always_comb
    begin
        ptr_o = ptr_i;
        case (mode_i)
            TBL_PREINC:  if (pre_i)  ptr_o = ptr_i + TPTR_STEP;
            TBL_POSTINC: if (!pre_i) ptr_o = ptr_i + TPTR_STEP;
            TBL_POSTDEC: if (!pre_i) ptr_o = ptr_i - TPTR_STEP;
            default:     ptr_o = ptr_i;
        endcase
        // low pointer bit picks the byte of the word
        byte_o = ptr_i[0] ? word_i[INSTR_W-1:DATA_W]
                          : word_i[DATA_W-1:0];
    end

endmodule

`default_nettype wire

// ===== dv/cstr_core_properties.sv
/*
 * port timing checks of the execution core.
 * assumes a bind to cstr_core, one clock, synchronous reset.
 */
`default_nettype none

module cstr_core_properties
    import cstr_pkg::*;
(
    input wire logic                    clk_sys_i,     // clock
    input wire logic                    sys_rst_i,     // reset
    input wire cstr_pkg::cstr_bus_req_t bus_i,         // register port
    input wire logic [7:0]              bus_rdata_o,   // read data
    input wire logic [15:0]             instr_i,       // instruction
    input wire logic                    instr_valid_i, // offered
    input wire logic                    instr_ready_o, // taken
    input wire logic                    pm_rd_o,       // pm read
    input wire logic                    sleep_o,       // halted
    input wire logic                    wdt_timeout_o  // overflow
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    wire logic take   = instr_valid_i && instr_ready_o;
    wire logic is_tbl = instr_i[15:2] == OPC_TBL_FETCH;
    wire logic is_pd  = instr_i == OPC_POWERDOWN;
    wire logic rd_pwr = bus_i.re && bus_i.addr == REG_POWER;

    property p_single;
        take && !is_tbl && !is_pd |=> !instr_ready_o[*3] ##1 instr_ready_o;
    endproperty
    a_single: assert property (p_single) else $error("op length");
    property p_tbl_len;
        take && is_tbl |=> !instr_ready_o[*7] ##1 instr_ready_o;
    endproperty
    a_tbl_len: assert property (p_tbl_len) else $error("tbl len");
    property p_tbl_rd;
        take && is_tbl |-> ##4 pm_rd_o;
    endproperty
    a_tbl_rd: assert property (p_tbl_rd) else $error("fetch read");
    property p_rd_pulse;
        pm_rd_o |=> !pm_rd_o;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("pm rd");
    property p_pd;
        take && is_pd |=> !sleep_o[*3] ##1 sleep_o;
    endproperty
    a_pd: assert property (p_pd) else $error("sleep entry");
    property p_halt;
        sleep_o |-> !instr_ready_o && !pm_rd_o;
    endproperty
    a_halt: assert property (p_halt) else $error("busy asleep");
    property p_pwr;
        sleep_o && rd_pwr |=> bus_rdata_o[PWR_TO_BIT:PWR_PD_BIT] == 2'h2;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power bits");
    property p_wdt_wake;
        $past(sleep_o) && wdt_timeout_o |-> !sleep_o;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("wd wake");
endmodule

`default_nettype wire

// ===== dv/cstr_core_tb.sv
/*
 * self-checking bench of the execution core.
 * assumes the core alone; the bench answers program memory reads.
 */
`default_nettype none

module cstr_core_tb
    import cstr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] op;
        logic [11:0] fa;
        logic [7:0]  w, f;
        logic [4:0]  st;
        logic [7:0]  ew, ef;
        logic [4:0]  est;
    } cstr_row_t;
    cstr_row_t rows [13] = '{
        '{16'h6810, 12'h010, 8'h12, 8'h5a, 5'h1f, 8'h12, 8'hff, 5'h1f},
        '{16'h6990, 12'h290, 8'h00, 8'h00, 5'h00, 8'h00, 8'hff, 5'h00},
        '{16'h6890, 12'hf90, 8'h00, 8'h00, 5'h00, 8'h00, 8'hff, 5'h00},
        '{16'h3a10, 12'h010, 8'h00, 8'h53, 5'h00, 8'h00, 8'h35, 5'h00},
        '{16'h3810, 12'h010, 8'h00, 8'h53, 5'h1f, 8'h35, 8'h53, 5'h1f},
        '{16'h0802, 12'h010, 8'h03, 8'h00, 5'h00, 8'hff, 8'h00, 5'h10},
        '{16'h5e10, 12'h010, 8'h02, 8'h03, 5'h00, 8'h02, 8'h01, 5'h03},
        '{16'h5c10, 12'h010, 8'h02, 8'h02, 5'h00, 8'h00, 8'h02, 5'h07},
        '{16'h5e10, 12'h010, 8'h01, 8'h80, 5'h00, 8'h01, 8'h7f, 5'h09},
        '{16'h5610, 12'h010, 8'h02, 8'h03, 5'h01, 8'h02, 8'hff, 5'h10},
        '{16'h5610, 12'h010, 8'h05, 8'h02, 5'h00, 8'h05, 8'h02, 5'h03},
        '{16'h5a10, 12'h010, 8'h0d, 8'h19, 5'h01, 8'h0d, 8'h0c, 5'h01},
        '{16'h5810, 12'h010, 8'h1a, 8'h1b, 5'h00, 8'h00, 8'h1b, 5'h07}};
    logic [20:0]   tp [4] = '{21'h01a357, 21'h1fffff, 21'h000000, 21'h01a357};
    logic          clk_sys_i = 1'b0;
    logic          sys_rst_i = 1'b1;
    logic          instr_valid = 1'b0;
    logic          wake = 1'b0;
    logic [15:0]   instr = '0;
    logic [15:0]   pm_data = '0;
    cstr_bus_req_t bus = '0;
    logic [7:0]    bus_rdata;
    logic          ready, pm_rd, sleep;
    logic [19:0]   pm_addr;
    int            err_total = 0, compares = 0, cyc = 0;

    cstr_core i_cstr_core (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .bus_i(bus), .bus_rdata_o(bus_rdata), .instr_i(instr),
        .instr_valid_i(instr_valid), .instr_ready_o(ready), .pm_rd_o(pm_rd),
        .pm_addr_o(pm_addr), .pm_data_i(pm_data), .wake_i(wake),
        .sleep_o(sleep), .wdt_timeout_o());

    // ------------------------------------------------------------
    // clock, program memory answer, hang guard
    // ------------------------------------------------------------
    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i)
    begin
        pm_data <= pm_rd ? {pm_addr[7:0] ^ 8'h5a, pm_addr[7:0]} : ~pm_data;
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [20:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] v);
        @(posedge clk_sys_i) bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_sys_i) bus <= '0;
    endtask
    task automatic rd(input logic [12:0] a, output logic [7:0] v);
        @(posedge clk_sys_i) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys_i) bus <= '0;
        #1 v = bus_rdata;
    endtask
    task automatic go(input logic [15:0] op);
        @(posedge clk_sys_i) instr <= op;
        instr_valid <= 1'b1;
        @(posedge clk_sys_i) instr_valid <= 1'b0;
    endtask
    task automatic wt(input int n);
        for (int k = 0; k < n; k++)
        begin
            @(posedge clk_sys_i);
            #1;
            if (ready) break;
        end
        chk("ready", 21'(ready), 21'h1);
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0]  d, h, u, lat;
        logic [20:0] p, e, np;
        repeat (12) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        wr(REG_BANKSEL, 8'h02);
        foreach (rows[i])
        begin
            wr(REG_WORKING, rows[i].w);
            wr(REG_STATUS, {3'h0, rows[i].st});
            wr({1'b1, rows[i].fa}, rows[i].f);
            go(rows[i].op);
            wt(8);
            rd(REG_WORKING, d);
            chk("work", 21'(d), 21'(rows[i].ew));
            rd({1'b1, rows[i].fa}, d);
            chk("file", 21'(d), 21'(rows[i].ef));
            rd(REG_STATUS, d);
            chk("flags", 21'(d[4:0]), 21'(rows[i].est));
        end
        $display("test ops done");
        for (int m = 0; m < 4; m++)
        begin
            p = tp[m];
            wr(REG_TPTR_L, p[7:0]);
            wr(REG_TPTR_H, p[15:8]);
            wr(REG_TPTR_U, {3'h0, p[20:16]});
            e = (m == 3) ? p + 21'h1 : p;
            np = (m == 2) ? p - 21'h1 : (m == 0) ? p : p + 21'h1;
            lat = e[0] ? e[8:1] ^ 8'h5a : e[8:1];
            go({OPC_TBL_FETCH, 2'(m)});
            wt(12);
            rd(REG_TLATCH, d);
            chk("latch", 21'(d), 21'(lat));
            rd(REG_TPTR_L, d);
            rd(REG_TPTR_H, h);
            rd(REG_TPTR_U, u);
            chk("ptr", {u[4:0], h, d}, np);
        end
        $display("test fetch done");
        @(posedge clk_sys_i) sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rd(REG_POWER, d);
        chk("pwr_rst", 21'(d), 21'h3);
        $display("test reset done");
        repeat (600) @(posedge clk_sys_i);
        go(OPC_POWERDOWN);
        repeat (5) @(posedge clk_sys_i);
        #1 chk("sleep", 21'(sleep), 21'h1);
        rd(REG_POWER, d);
        chk("pwr_pd", 21'(d), 21'h6);
        rd(REG_WDOG, d);
        chk("wdog", 21'(d), 21'h0);
        @(posedge clk_sys_i) wake <= 1'b1;
        @(posedge clk_sys_i) wake <= 1'b0;
        wt(4);
        rd(REG_POWER, d);
        chk("pwr_wake", 21'(d), 21'h2);
        go(OPC_POWERDOWN);
        wt(70000);
        rd(REG_POWER, d);
        chk("pwr_wdog", 21'(d), 21'h0);
        $display("test sleep done");
        report_and_stop();
    end
endmodule

bind cstr_core cstr_core_properties i_cstr_core_properties (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i),
    .bus_rdata_o(bus_rdata_o), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o),
    .pm_rd_o(pm_rd_o), .sleep_o(sleep_o), .wdt_timeout_o(wdt_timeout_o));

`default_nettype wire
